// [rtl/meio_pkg.sv]
// Package with register map, field positions, reset values and timing counts
package meio_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_EOM_WIDTH = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_PANEL_SAVED = 8'h10;
	// Control register fields
	localparam int CTRL_EXT_TRIGGER_IN_EXT = 0;
	localparam int CTRL_INIT_CONT = 1;
	localparam int CTRL_FILTER_EN = 2;
	localparam int CTRL_EOM_HOLD = 3;
	localparam int CTRL_OUT_BCD = 4;
	localparam int CTRL_SCAN_EN = 5;
	localparam int CTRL_IF_PRINTER = 6;
	localparam int CTRL_W = 7;
	// Command register fields
	localparam int CMD_INIT = 0;
	// Status register fields
	localparam int STAT_ARMED = 0;
	localparam int STAT_EOM = 1;
	localparam int STAT_LOAD_REFUSED = 2;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h02;
	localparam logic [15:0] EOM_WIDTH_RESET = 16'h000A;
	localparam logic [15:0] PANEL_SAVED_RESET = 16'h0000;
	// Timing, times in ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int EXT_TRIGGER_IN_ON_MIN_NS = 100000;
	localparam int FILTER_ON_NS = 5000000;
	localparam int US_NS = 1000;
	// Least times round up to whole cycles
	localparam int EXT_TRIGGER_IN_ON_CYC = (EXT_TRIGGER_IN_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_ON_CYC = (FILTER_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int US_CYC = US_NS / CLK_PERIOD_NS;
	localparam int QUAL_CNT_W = 24;
endpackage : meio_pkg

// [rtl/meio_in_qual.sv]
// Pin synchroniser and on-time qualifier for the trigger and print inputs
`timescale 1ns/1ns
module meio_in_qual #(
	parameter int ON_CYC = meio_pkg::EXT_TRIGGER_IN_ON_CYC,
	parameter int FILT_CYC = meio_pkg::FILTER_ON_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Pin and mode
	input wire logic pin_in,
	input wire logic filter_en,
	// Qualified event
	output logic qual_pulse
);
	logic sync1_q;
	logic sync2_q;
	logic fired_q;
	logic [meio_pkg::QUAL_CNT_W-1:0] on_cnt_q;
	logic [meio_pkg::QUAL_CNT_W-1:0] need;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// R04 longer filter time
	assign need = filter_en ? meio_pkg::QUAL_CNT_W'(FILT_CYC - 1)
		: meio_pkg::QUAL_CNT_W'(ON_CYC - 1);

	// R02 minimum on time
	always_ff @(posedge sys_clk) begin
		if (rst || !sync2_q) begin
			on_cnt_q <= '0;
		end else if (on_cnt_q < need) begin
			on_cnt_q <= on_cnt_q + 1'b1;
		end
	end

	// One event per asserted period; re-armed once the pin drops
	always_ff @(posedge sys_clk) begin
		if (rst || !sync2_q) begin
			fired_q <= 1'b0;
		end else if (qual_pulse) begin
			fired_q <= 1'b1;
		end
	end

	assign qual_pulse = sync2_q && !fired_q && (on_cnt_q >= need);

	// R02 on time reached
	qual_time_a: assert property (@(posedge sys_clk) disable iff (rst) // R02
		qual_pulse |-> $past(sync2_q) && (on_cnt_q >= need))
		else $error("trigger accepted before its on time");
endmodule : meio_in_qual

// [rtl/meio_eom_gen.sv]
// End-of-measurement output in pulse or hold mode
`timescale 1ns/1ns
module meio_eom_gen (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Mode
	input wire logic hold_mode,
	input wire logic [15:0] width_us,
	// Measurement events
	input wire logic meas_begin,
	input wire logic meas_done,
	// Output
	output logic eom_out
);
	logic [7:0] div_q;
	logic us_tick;
	logic [15:0] left_q;
	logic hold_q;

	// Microsecond enable divider; restarts at completion so a pulse never falls short
	always_ff @(posedge sys_clk) begin
		if (rst || us_tick || meas_done) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end
	assign us_tick = (div_q == 8'(meio_pkg::US_CYC - 1));

	// R07 pulse width count
	always_ff @(posedge sys_clk) begin
		if (rst || hold_mode) begin
			left_q <= 16'h0000;
		end else if (meas_done) begin
			left_q <= (width_us == 16'h0000) ? 16'h0001 : width_us;
		end else if (us_tick && left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end

	// R08 hold until next measurement
	always_ff @(posedge sys_clk) begin
		if (rst || !hold_mode) begin
			hold_q <= 1'b0;
		end else if (meas_done) begin
			hold_q <= 1'b1;
		end else if (meas_begin) begin
			// R09 clear on next begin
			hold_q <= 1'b0;
		end
	end

	// R06 assert on completion
	assign eom_out = hold_mode ? hold_q : (left_q != 16'h0000);

	sequence eom_held_s;
		eom_out [*8];
	endsequence

	eom_rise_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		meas_done |=> eom_out)
		else $error("end of measurement not asserted after completion");
	eom_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // R07
		!hold_mode && meas_done ##1 !hold_mode |-> eom_held_s)
		else $error("end of measurement pulse too short");
	eom_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R09
		hold_mode && meas_begin && !meas_done ##1 hold_mode |-> !eom_out)
		else $error("held end of measurement not cleared at next begin");
endmodule : meio_eom_gen

// [rtl/meio_top.sv]
// External control port of the meter: trigger, print, load, judgment, BCD and scan outputs
// Function
// R01: With the internal trigger source selected the external trigger input never starts a measurement.
// R02: The controller holds the external trigger high at least 0.1 ms for it to be recognised.
// R03: The controller keeps the external trigger low at least 1 ms between triggers.
// R04: With the input filter on, trigger and print need a longer on time before acceptance.
// R05: With continuous initiation off the block waits for triggers only after an init command.
// R06: The end-of-measurement output asserts when a measurement completes.
// R07: In pulse mode end-of-measurement stands for the programmed width.
// R08: In hold mode end-of-measurement stands until the next measurement.
// R09: In hold mode end-of-measurement drops when the next measurement begins.
// R10: Output mode picks judgment or BCD outputs, and in BCD mode upper and lower results are ORed.
// R11: In BCD mode the low-digit select picks the lower digits, otherwise the upper are shown.
// R12: Range code outputs are driven only while the low-digit select is high.
// R13: A load strobe switches channels only while the channel switch enable is high.
// R14: Scan total outputs are driven only with scan on and all channels measured.
// R15: A load never restores a panel number under which nothing is saved.
// R16: The print input prints only when the interface is set to the printer.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module meio_top #(
	parameter int EXT_TRIGGER_IN_ON_CYC = meio_pkg::EXT_TRIGGER_IN_ON_CYC,
	parameter int FILTER_ON_CYC = meio_pkg::FILTER_ON_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Control input pins
	input wire logic ext_trigger_in,
	input wire logic print_in,
	input wire logic load_strobe_in,
	input wire logic [3:0] load_code_in,
	input wire logic channel_switch_enable,
	input wire logic bcd_low_select_in,
	// Measurement core
	input wire logic int_ext_trigger_in_tick,
	input wire logic meas_begin,
	input wire logic meas_complete,
	input wire logic judge_hi_in,
	input wire logic judge_in_in,
	input wire logic judge_lo_in,
	input wire logic [15:0] bcd_upper_in,
	input wire logic [15:0] bcd_lower_in,
	input wire logic [2:0] range_code_in,
	input wire logic scan_all_done,
	input wire logic scan_pass_in,
	input wire logic scan_fail_in,
	input wire logic scan_err_in,
	output logic meas_start_out,
	output logic print_req_out,
	output logic chan_switch_out,
	output logic panel_load_out,
	output logic [3:0] sel_code_out,
	// Output pins
	output logic measurement_done_out,
	output logic upper_limit_judge,
	output logic in_limit_judge,
	output logic lower_limit_judge,
	output logic [15:0] bcd_out,
	output logic [2:0] range_out,
	output logic scan_pass_out,
	output logic scan_fail_out,
	output logic scan_err_out
);
	logic [meio_pkg::CTRL_W-1:0] ctrl_q;
	logic [15:0] eom_width_q;
	logic [15:0] panel_saved_q;
	logic armed_q;
	logic refused_q;
	logic [31:0] rdata_q;
	logic [6:0] pin1_q;
	logic [6:0] pin2_q;
	logic load_prev_q;
	logic ext_trigger_in_qual;
	logic print_qual;
	logic load_edge;
	logic low_sel_s;
	logic mux_en_s;
	logic [3:0] code_s;
	logic init_cmd;
	logic eom;
	logic ext_trigger_in_ext;
	logic init_cont;
	logic bcd_mode;
	logic scan_ok;

	assign ext_trigger_in_ext = ctrl_q[meio_pkg::CTRL_EXT_TRIGGER_IN_EXT];
	assign init_cont = ctrl_q[meio_pkg::CTRL_INIT_CONT];
	assign bcd_mode = ctrl_q[meio_pkg::CTRL_OUT_BCD];
	assign init_cmd = reg_wr && reg_addr == meio_pkg::REG_CMD && reg_wdata[meio_pkg::CMD_INIT];

	// Register writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_q <= meio_pkg::CTRL_RESET;
			eom_width_q <= meio_pkg::EOM_WIDTH_RESET;
			panel_saved_q <= meio_pkg::PANEL_SAVED_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				meio_pkg::REG_CTRL: ctrl_q <= reg_wdata[meio_pkg::CTRL_W-1:0];
				meio_pkg::REG_EOM_WIDTH: eom_width_q <= reg_wdata[15:0];
				meio_pkg::REG_PANEL_SAVED: panel_saved_q <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk) begin
		if (rst || !reg_rd) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				meio_pkg::REG_CTRL: rdata_q <= 32'(ctrl_q);
				meio_pkg::REG_EOM_WIDTH: rdata_q <= {16'h0000, eom_width_q};
				meio_pkg::REG_STATUS: rdata_q <= {29'h0000_0000, refused_q, eom, armed_q};
				meio_pkg::REG_PANEL_SAVED: rdata_q <= {16'h0000, panel_saved_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign reg_rdata = rdata_q;

	// Pin synchronisers for the remaining inputs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin1_q <= 7'h00;
			pin2_q <= 7'h00;
		end else begin
			pin1_q <= {bcd_low_select_in, channel_switch_enable, load_code_in, load_strobe_in};
			pin2_q <= pin1_q;
		end
	end
	assign code_s = pin2_q[4:1];
	assign mux_en_s = pin2_q[5];
	assign low_sel_s = pin2_q[6];

	meio_in_qual #(
		.ON_CYC(EXT_TRIGGER_IN_ON_CYC),
		.FILT_CYC(FILTER_ON_CYC)
	) u_ext_trigger_in_qual (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(ext_trigger_in),
		.filter_en(ctrl_q[meio_pkg::CTRL_FILTER_EN]),
		.qual_pulse(ext_trigger_in_qual)
	);

	meio_in_qual #(
		.ON_CYC(EXT_TRIGGER_IN_ON_CYC),
		.FILT_CYC(FILTER_ON_CYC)
	) u_print_qual (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(print_in),
		.filter_en(ctrl_q[meio_pkg::CTRL_FILTER_EN]),
		.qual_pulse(print_qual)
	);

	// R05 trigger wait after init
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (init_cmd) begin
			armed_q <= 1'b1;
		end else if (meas_start_out) begin
			armed_q <= 1'b0;
		end
	end

	// R01 source selects the trigger
	assign meas_start_out = (init_cont || armed_q) && (ext_trigger_in_ext ? ext_trigger_in_qual : int_ext_trigger_in_tick);

	// R16 print only to printer
	assign print_req_out = print_qual && ctrl_q[meio_pkg::CTRL_IF_PRINTER];

	// Load strobe edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			load_prev_q <= 1'b0;
		end else begin
			load_prev_q <= pin2_q[0];
		end
	end
	assign load_edge = pin2_q[0] && !load_prev_q;

	// R13 channel switch gated; R15 only saved panels load
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chan_switch_out <= 1'b0;
			panel_load_out <= 1'b0;
			sel_code_out <= 4'h0;
		end else begin
			chan_switch_out <= load_edge && mux_en_s;
			panel_load_out <= load_edge && !mux_en_s && panel_saved_q[code_s];
			if (load_edge) begin
				sel_code_out <= code_s;
			end
		end
	end

	// Refused-load flag: set wins over the write-one clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			refused_q <= 1'b0;
		end else if (load_edge && !mux_en_s && !panel_saved_q[code_s]) begin
			refused_q <= 1'b1;
		end else if (reg_wr && reg_addr == meio_pkg::REG_STATUS
			&& reg_wdata[meio_pkg::STAT_LOAD_REFUSED]) begin
			refused_q <= 1'b0;
		end
	end

	meio_eom_gen u_eom (
		.sys_clk(sys_clk),
		.rst(rst),
		.hold_mode(ctrl_q[meio_pkg::CTRL_EOM_HOLD]),
		.width_us(eom_width_q),
		.meas_begin(meas_begin),
		.meas_done(meas_complete),
		.eom_out(eom)
	);
	assign measurement_done_out = eom;

	// R10 judgment or BCD outputs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			upper_limit_judge <= 1'b0;
			in_limit_judge <= 1'b0;
			lower_limit_judge <= 1'b0;
		end else if (bcd_mode) begin
			upper_limit_judge <= judge_hi_in || judge_lo_in;
			in_limit_judge <= judge_in_in;
			lower_limit_judge <= 1'b0;
		end else begin
			upper_limit_judge <= judge_hi_in;
			in_limit_judge <= judge_in_in;
			lower_limit_judge <= judge_lo_in;
		end
	end

	// R11 digit select; R12 range gated
	always_ff @(posedge sys_clk) begin
		if (rst || !bcd_mode) begin
			bcd_out <= 16'h0000;
		end else begin
			bcd_out <= low_sel_s ? bcd_lower_in : bcd_upper_in;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst || !low_sel_s) begin
			range_out <= 3'h0;
		end else begin
			range_out <= range_code_in;
		end
	end

	// R14 scan totals gated
	assign scan_ok = ctrl_q[meio_pkg::CTRL_SCAN_EN] && scan_all_done;
	always_ff @(posedge sys_clk) begin
		if (rst || !scan_ok) begin
			scan_pass_out <= 1'b0;
			scan_fail_out <= 1'b0;
			scan_err_out <= 1'b0;
		end else begin
			scan_pass_out <= scan_pass_in;
			scan_fail_out <= scan_fail_in;
			scan_err_out <= scan_err_in;
		end
	end

	ext_trigger_in_source_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
		meas_start_out && !ext_trigger_in_ext |-> int_ext_trigger_in_tick)
		else $error("measurement started by external input while internal");
	arm_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		meas_start_out && !init_cont && !init_cmd |=> !armed_q)
		else $error("trigger wait not left after trigger");
	bcd_merge_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
		bcd_mode && (judge_hi_in || judge_lo_in) |=> upper_limit_judge && !lower_limit_judge)
		else $error("BCD mode did not merge upper and lower results");
	low_digit_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
		bcd_mode && !low_sel_s |=> bcd_out == $past(bcd_upper_in))
		else $error("upper digits not shown without low select");
	range_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
		!low_sel_s |=> range_out == 3'h0)
		else $error("range driven without low select");
	load_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
		chan_switch_out |-> $past(mux_en_s) && $past(load_edge))
		else $error("channel switched without enable");
	panel_saved_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
		panel_load_out |-> $past(panel_saved_q[code_s]))
		else $error("load from empty panel");
	scan_total_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
		!scan_ok |=> !scan_pass_out && !scan_fail_out && !scan_err_out)
		else $error("scan totals driven before scan complete");
	print_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
		print_req_out |-> ctrl_q[meio_pkg::CTRL_IF_PRINTER])
		else $error("print requested with interface not on printer");
endmodule : meio_top

// [bench/meio_ctrl_model.sv]
// Outside controller model driving the meter's control pins
`timescale 1ns/1ns
module meio_ctrl_model #(
	parameter int OFF_CYC = 40
) (
	// Clock
	input wire logic sys_clk,
	// Control pins
	output logic ext_trigger_in,
	output logic print_in,
	output logic load_strobe_in,
	output logic [3:0] load_code_in,
	output logic channel_switch_enable,
	output logic bcd_low_select_in
);
	initial begin
		ext_trigger_in = 1'b0;
		print_in = 1'b0;
		load_strobe_in = 1'b0;
		load_code_in = 4'h0;
		channel_switch_enable = 1'b0;
		bcd_low_select_in = 1'b0;
	end

	// on time chosen by caller, then a fixed off time of OFF_CYC cycles
	task automatic pulse(input bit prn, input int on_cyc);
		@(posedge sys_clk);
		if (prn) print_in <= 1'b1;
		else ext_trigger_in <= 1'b1;
		repeat (on_cyc) @(posedge sys_clk);
		print_in <= 1'b0;
		ext_trigger_in <= 1'b0;
		repeat (OFF_CYC) @(posedge sys_clk);
	endtask : pulse

	// code is only promised while the strobe is high
	task automatic load(input logic [3:0] code, input logic en);
		@(posedge sys_clk);
		load_code_in <= code;
		channel_switch_enable <= en;
		load_strobe_in <= 1'b1;
		repeat (6) @(posedge sys_clk);
		load_strobe_in <= 1'b0;
		load_code_in <= ~code;
		repeat (OFF_CYC) @(posedge sys_clk);
	endtask : load

	// low digit select is a plain level
	task automatic sel(input logic lvl);
		@(posedge sys_clk);
		bcd_low_select_in <= lvl;
	endtask : sel
endmodule : meio_ctrl_model

// [bench/meio_top_bench.sv]
// Self-checking bench for the meter external control port
`timescale 1ns/1ns
module meio_top_bench;
	localparam int TON = 8;
	localparam int FON = 32;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic ext_trigger_in, print_in, load_strobe_in, channel_switch_enable, bcd_low_select_in;
	logic [3:0] load_code_in, sel_code_out;
	logic int_ext_trigger_in_tick = 1'b0, meas_begin = 1'b0, meas_complete = 1'b0;
	logic judge_hi_in = 1'b0, judge_in_in = 1'b0, judge_lo_in = 1'b0;
	logic [15:0] bcd_upper_in = 16'h1234, bcd_lower_in = 16'h5678, bcd_out;
	logic [2:0] range_code_in = 3'h5, range_out;
	logic scan_all_done = 1'b0, scan_pass_in = 1'b1, scan_fail_in = 1'b1, scan_err_in = 1'b1;
	logic meas_start_out, print_req_out, chan_switch_out, panel_load_out;
	logic measurement_done_out, upper_limit_judge, in_limit_judge, lower_limit_judge;
	logic scan_pass_out, scan_fail_out, scan_err_out;
	int err_total = 0, n_checks = 0, n_st = 0, n_pr = 0, n_cs = 0, n_pl = 0;
	int s_st, s_pr, s_cs, s_pl, w;
	logic [31:0] d;

	always #2 sys_clk = ~sys_clk;

	meio_top #(.EXT_TRIGGER_IN_ON_CYC(TON), .FILTER_ON_CYC(FON)) dut_u (.sys_clk, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_trigger_in, .print_in, .load_strobe_in,
		.load_code_in, .channel_switch_enable, .bcd_low_select_in, .int_ext_trigger_in_tick, .meas_begin,
		.meas_complete, .judge_hi_in, .judge_in_in, .judge_lo_in, .bcd_upper_in, .bcd_lower_in,
		.range_code_in, .scan_all_done, .scan_pass_in, .scan_fail_in, .scan_err_in,
		.meas_start_out, .print_req_out, .chan_switch_out, .panel_load_out, .sel_code_out,
		.measurement_done_out, .upper_limit_judge, .in_limit_judge, .lower_limit_judge,
		.bcd_out, .range_out, .scan_pass_out, .scan_fail_out, .scan_err_out);

	meio_ctrl_model #(.OFF_CYC(40)) ctl_u (.sys_clk, .ext_trigger_in, .print_in,
		.load_strobe_in, .load_code_in, .channel_switch_enable, .bcd_low_select_in);

	// One-cycle pulses are counted so that none slips by unseen
	always @(posedge sys_clk) begin
		if (meas_start_out === 1'b1) n_st++;
		if (print_req_out === 1'b1) n_pr++;
		if (chan_switch_out === 1'b1) n_cs++;
		if (panel_load_out === 1'b1) n_pl++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// Bytes: starts, prints, channel switches, panel loads since last call
	task automatic evts(input logic [31:0] exp, input string msg);
		chk({8'(n_st - s_st), 8'(n_pr - s_pr), 8'(n_cs - s_cs), 8'(n_pl - s_pl)}, exp, msg);
		s_st = n_st;
		s_pr = n_pr;
		s_cs = n_cs;
		s_pl = n_pl;
	endtask : evts

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic mpulse(input bit beg);
		@(posedge sys_clk);
		if (beg) meas_begin <= 1'b1;
		else meas_complete <= 1'b1;
		@(posedge sys_clk);
		meas_begin <= 1'b0;
		meas_complete <= 1'b0;
		#1;
	endtask : mpulse

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h00, d); chk(d, 32'h0000_0002, "ctrl reset");
		rd(8'h04, d); chk(d, 32'h0000_000A, "eom width reset");
		rd(8'h10, d); chk(d, 32'h0000_0000, "panel mask reset");
		rd(8'h14, d); chk(d, 32'h0000_0000, "unmapped read");
		evts(32'h0000_0000, "idle");
		ctl_u.pulse(0, 4 * TON); evts(32'h0000_0000, "pin with internal source");
		@(posedge sys_clk) int_ext_trigger_in_tick <= 1'b1;
		@(posedge sys_clk) int_ext_trigger_in_tick <= 1'b0;
		tick(2); evts(32'h0100_0000, "internal tick");
		$display("test trigger source done");
		wr(8'h00, 32'h0000_0003);
		ctl_u.pulse(0, TON - 3); evts(32'h0000_0000, "short trigger");
		ctl_u.pulse(0, 4 * TON); evts(32'h0100_0000, "long trigger once");
		wr(8'h00, 32'h0000_0007);
		ctl_u.pulse(0, FON - 4); evts(32'h0000_0000, "filtered short");
		ctl_u.pulse(0, FON + 4); evts(32'h0100_0000, "filtered long");
		wr(8'h00, 32'h0000_0001);
		ctl_u.pulse(0, 2 * TON); evts(32'h0000_0000, "not armed");
		wr(8'h08, 32'h0000_0001);
		rd(8'h0C, d); chk(d & 32'h0000_0001, 32'h0000_0001, "armed");
		ctl_u.pulse(0, 2 * TON); evts(32'h0100_0000, "armed trigger");
		ctl_u.pulse(0, 2 * TON); evts(32'h0000_0000, "arm used up");
		$display("test trigger qualify done");
		wr(8'h00, 32'h0000_0003);
		ctl_u.pulse(1, 2 * TON); evts(32'h0000_0000, "print no printer");
		wr(8'h00, 32'h0000_0043);
		ctl_u.pulse(1, 2 * TON); evts(32'h0001_0000, "print to printer");
		$display("test print done");
		wr(8'h04, 32'h0000_0001);
		mpulse(0); chk(measurement_done_out, 1'b1, "done rises");
		w = 0;
		while (measurement_done_out === 1'b1 && w < 1000) begin
			tick(1);
			w++;
		end
		if (w >= 1000) begin
			err_total++;
			print_verdict();
		end
		chk(32'(w >= 249 && w <= 501), 32'h0000_0001, "pulse width");
		wr(8'h00, 32'h0000_000B);
		mpulse(0); tick(300); chk(measurement_done_out, 1'b1, "hold stays");
		mpulse(1); chk(measurement_done_out, 1'b0, "hold drops");
		mpulse(0); chk(measurement_done_out, 1'b1, "hold rises again");
		$display("test end of measurement done");
		wr(8'h00, 32'h0000_0003);
		@(posedge sys_clk) judge_hi_in <= 1'b1;
		judge_in_in <= 1'b1;
		tick(3); chk({upper_limit_judge, in_limit_judge, lower_limit_judge, bcd_out}, 19'h6_0000,
			"judge");
		wr(8'h00, 32'h0000_0013);
		@(posedge sys_clk) judge_hi_in <= 1'b0;
		judge_lo_in <= 1'b1;
		tick(3); chk({upper_limit_judge, lower_limit_judge, range_out, bcd_out}, {5'h10, 16'h1234},
			"bcd upper");
		ctl_u.sel(1'b1);
		tick(5); chk({range_out, bcd_out}, {3'h5, 16'h5678}, "bcd lower");
		ctl_u.sel(1'b0);
		$display("test output mode done");
		ctl_u.load(4'h3, 1'b1); evts(32'h0000_0100, "channel switch");
		chk(sel_code_out, 4'h3, "switch code");
		ctl_u.load(4'h5, 1'b0); evts(32'h0000_0000, "unsaved panel");
		rd(8'h0C, d); chk(d & 32'h0000_0004, 32'h0000_0004, "refused flag");
		wr(8'h0C, 32'h0000_0004);
		rd(8'h0C, d); chk(d & 32'h0000_0004, 32'h0000_0000, "flag cleared");
		wr(8'h10, 32'h0000_0020);
		ctl_u.load(4'h5, 1'b0); evts(32'h0000_0001, "saved panel");
		chk(sel_code_out, 4'h5, "panel code");
		$display("test load done");
		@(posedge sys_clk) scan_all_done <= 1'b1;
		tick(3); chk({scan_pass_out, scan_fail_out, scan_err_out}, 3'h0, "scan off");
		wr(8'h00, 32'h0000_0023);
		@(posedge sys_clk) scan_all_done <= 1'b0;
		tick(3); chk({scan_pass_out, scan_fail_out, scan_err_out}, 3'h0, "not all done");
		@(posedge sys_clk) scan_all_done <= 1'b1;
		tick(3); chk({scan_pass_out, scan_fail_out, scan_err_out}, 3'h7, "scan total");
		$display("test scan done");
		print_verdict();
	end
endmodule : meio_top_bench
